// ==== shared/dpid_cfg.svh ====
`ifndef DPID_CFG_SVH
`define DPID_CFG_SVH
// Register word indices (byte address is four times the index)
`define DPID_IDX_CTRL 5'h00
`define DPID_IDX_REF_MIN 5'h01
`define DPID_IDX_REF_MAX 5'h02
`define DPID_IDX_FB_LOW 5'h03
`define DPID_IDX_FB_HIGH 5'h04
`define DPID_IDX_BUS_REF 5'h05
`define DPID_IDX_PRESET_REF 5'h06
`define DPID_IDX_START_FREQ 5'h07
`define DPID_IDX_SPD_BANK 5'h08
`define DPID_IDX_PRC_BANK 5'h0D
`define DPID_IDX_STATUS 5'h12
`define DPID_IDX_FEEDBACK 5'h13
`define DPID_IDX_ERROR 5'h14
`define DPID_NUM_CFG 18
// Control field positions
`define DPID_CTRL_MODE_LSB 0
`define DPID_CTRL_INV 2
`define DPID_CTRL_AW 3
`define DPID_CTRL_RUN 4
`define DPID_CTRL_FB_VOLT 5
`define DPID_CTRL_FB_CUR 6
`define DPID_CTRL_FB_PULSE 7
`define DPID_CTRL_REF_VOLT 8
`define DPID_CTRL_REF_CUR 9
`define DPID_CTRL_REF_BUS 10
`define DPID_CTRL_REF_PRESET 11
`define DPID_CTRL_UNIT_LSB 16
`define DPID_UNIT_RPM 6'h03
// Reset values
`define DPID_RST_CTRL 32'h0000_0029
`define DPID_RST_REF_MAX 32'h0000_0100
`define DPID_RST_FB_HIGH 32'h0000_05DC
`define DPID_RST_KP 32'h0000_0100
`define DPID_RST_TI 32'h0000_0064
`define DPID_RST_TD 32'h0000_0014
`define DPID_RST_DLIM 32'h0000_0500
`define DPID_RST_LPF 32'h0000_0064
// Control sample period
`define DPID_SAMPLE_NS 1000000
`define DPID_CLK_NS 5
`define DPID_SAMPLE_CYC (`DPID_SAMPLE_NS / `DPID_CLK_NS)
`endif

// ==== shared/dpid_pkg.sv ====
package dpid_pkg;
    // Regulator configuration codes
    typedef enum logic [1:0] {
        DPID_MODE_SPEED = 2'b01,
        DPID_MODE_PROCESS = 2'b11
    } dpid_mode_t;
    // Regulation sequence
    typedef enum logic [1:0] {
        DPID_ST_IDLE = 2'b00,
        DPID_ST_START = 2'b01,
        DPID_ST_REG = 2'b10
    } dpid_state_t;
    // One regulator's tuning bank
    typedef struct packed {
        logic [15:0] lpf;
        logic [15:0] dlim;
        logic [15:0] td;
        logic [15:0] ti;
        logic [15:0] kp;
    } dpid_bank_t;
    // Pin inputs that are synchronised together
    typedef struct packed {
        logic [15:0] fb_volt;
        logic [15:0] fb_cur;
        logic [15:0] fb_pulse;
        logic [15:0] ref_volt;
        logic [15:0] ref_cur;
        logic [15:0] out_freq;
        logic [2:0] limit_hit;
    } dpid_pins_t;
endpackage : dpid_pkg

// ==== core/dpid_top.sv ====
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`include "dpid_cfg.svh"
module dpid_top #(
    parameter int SAMPLE_CYC = `DPID_SAMPLE_CYC
) (
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [6:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic [15:0] FB_VOLT_IN,
    input wire logic [15:0] FB_CUR_IN,
    input wire logic [15:0] FB_PULSE_IN,
    input wire logic [15:0] REF_VOLT_IN,
    input wire logic [15:0] REF_CUR_IN,
    input wire logic [15:0] OUT_FREQ_IN,
    input wire logic [2:0] LIMIT_HIT_IN,
    output logic [15:0] FREQ_CMD_OUT,
    output logic REG_ACTIVE_OUT
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_s1_r, rst_n_r;
    dpid_pkg::dpid_pins_t pins_raw, pins_s1_r, pins_r;
    assign pins_raw = '{fb_volt: FB_VOLT_IN, fb_cur: FB_CUR_IN,
        fb_pulse: FB_PULSE_IN, ref_volt: REF_VOLT_IN, ref_cur: REF_CUR_IN,
        out_freq: OUT_FREQ_IN, limit_hit: LIMIT_HIT_IN};

    // Two-stage reset release
    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // Two-stage pin synchroniser
    always_ff @(posedge CLK_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pins_s1_r <= '0;
            pins_r <= '0;
        end
        else
        begin
            pins_s1_r <= pins_raw;
            pins_r <= pins_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave and configuration registers
    // ----------------------------------------------------------------
    logic [31:0] cfg_r [0:`DPID_NUM_CFG-1];
    logic wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] status_w, feedback_w, error_w;
    wire [4:0] widx = AVS_ADDRESS_IN[6:2];
    wire req = AVS_READ_IN | AVS_WRITE_IN;
    wire wr_take = AVS_WRITE_IN & ~wait_r;

    // One wait cycle, then the request is taken
    always_ff @(posedge CLK_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            wait_r <= ~(req & wait_r);
            rdata_r <= rdata_nxt;
        end
    end

    // Read decode; unmapped words read zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (widx < 5'(`DPID_NUM_CFG))
            rdata_nxt = cfg_r[widx];
        else if (widx == `DPID_IDX_STATUS)
            rdata_nxt = status_w;
        else if (widx == `DPID_IDX_FEEDBACK)
            rdata_nxt = feedback_w;
        else if (widx == `DPID_IDX_ERROR)
            rdata_nxt = error_w;
    end

    // Writable words; bus reference reachable only here
    for (genvar g = 0; g < `DPID_NUM_CFG; g++)
    begin : g_cfg
        localparam logic [31:0] rst_val = (g == 0) ? `DPID_RST_CTRL :
            (g == 2) ? `DPID_RST_REF_MAX :
            (g == 4) ? `DPID_RST_FB_HIGH :
            (g == 8 || g == 13) ? `DPID_RST_KP :
            (g == 9 || g == 14) ? `DPID_RST_TI :
            (g == 10 || g == 15) ? `DPID_RST_TD :
            (g == 11 || g == 16) ? `DPID_RST_DLIM :
            (g == 12 || g == 17) ? `DPID_RST_LPF : 32'h0000_0000;
        always_ff @(posedge CLK_IN or negedge rst_n_r)
        begin
            if (!rst_n_r)
                cfg_r[g] <= rst_val;
            else if (wr_take && widx == 5'(g))
                cfg_r[g] <= (g == 0) ? AVS_WRITEDATA_IN :
                    {16'h0000, AVS_WRITEDATA_IN[15:0]};
        end
    end

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    wire [31:0] ctrl = cfg_r[`DPID_IDX_CTRL];
    wire [1:0] mode = ctrl[`DPID_CTRL_MODE_LSB +: 2];
    wire is_spd = mode == dpid_pkg::DPID_MODE_SPEED;
    wire is_prc = mode == dpid_pkg::DPID_MODE_PROCESS;
    wire run = ctrl[`DPID_CTRL_RUN] & (is_spd | is_prc);
    wire inv = is_prc & ctrl[`DPID_CTRL_INV];
    wire aw_en = is_prc & ctrl[`DPID_CTRL_AW];
    wire fb_cur_en = ctrl[`DPID_CTRL_FB_CUR];
    wire [5:0] unit = is_spd ? `DPID_UNIT_RPM :
        ctrl[`DPID_CTRL_UNIT_LSB +: 6];
    dpid_pkg::dpid_bank_t spd_bank, prc_bank, bank;
    assign spd_bank = {cfg_r[12][15:0], cfg_r[11][15:0], cfg_r[10][15:0],
        cfg_r[9][15:0], cfg_r[8][15:0]};
    assign prc_bank = {cfg_r[17][15:0], cfg_r[16][15:0], cfg_r[15][15:0],
        cfg_r[14][15:0], cfg_r[13][15:0]};
    assign bank = is_prc ? prc_bank : spd_bank;

    // ----------------------------------------------------------------
    // Sample tick
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic tick_r;

    // Fixed control sample period
    always_ff @(posedge CLK_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= tick_cnt_r == 32'(SAMPLE_CYC - 1);
            tick_cnt_r <= (tick_cnt_r == 32'(SAMPLE_CYC - 1)) ?
                32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Reference and feedback handling
    // ----------------------------------------------------------------
    function automatic logic signed [47:0] sx(input logic [15:0] v);
        sx = 48'(signed'(v));
    endfunction : sx

    // Sum of active references and feedbacks
    wire signed [47:0] ref_sum = (ctrl[`DPID_CTRL_REF_BUS] ?
            sx(cfg_r[`DPID_IDX_BUS_REF][15:0]) : 48'sh0)
        + (ctrl[`DPID_CTRL_REF_PRESET] ?
            sx(cfg_r[`DPID_IDX_PRESET_REF][15:0]) : 48'sh0)
        + (ctrl[`DPID_CTRL_REF_VOLT] ? sx(pins_r.ref_volt) : 48'sh0)
        + ((ctrl[`DPID_CTRL_REF_CUR] & ~fb_cur_en) ?
            sx(pins_r.ref_cur) : 48'sh0);
    wire signed [47:0] fb_sum = (ctrl[`DPID_CTRL_FB_VOLT] ?
            sx(pins_r.fb_volt) : 48'sh0)
        + (fb_cur_en ? sx(pins_r.fb_cur) : 48'sh0)
        + (ctrl[`DPID_CTRL_FB_PULSE] ? sx(pins_r.fb_pulse) : 48'sh0);
    wire signed [47:0] fb_lo = sx(cfg_r[`DPID_IDX_FB_LOW][15:0]);
    wire signed [47:0] fb_hi = sx(cfg_r[`DPID_IDX_FB_HIGH][15:0]);
    wire signed [47:0] ref_min = sx(cfg_r[`DPID_IDX_REF_MIN][15:0]);
    wire signed [47:0] ref_scl = (ref_sum *
        $signed({32'h0, cfg_r[`DPID_IDX_REF_MAX][15:0]})) >>> 8;
    wire signed [47:0] ref_flr = (ref_scl < ref_min) ? ref_min : ref_scl;
    wire signed [47:0] ref_cl = (ref_flr > fb_hi) ? fb_hi :
        (ref_flr < fb_lo) ? fb_lo : ref_flr;

    // ----------------------------------------------------------------
    // PID terms
    // ----------------------------------------------------------------
    logic signed [47:0] fbf_r, integ_r, err_prev_r;
    wire signed [47:0] kp = $signed({32'h0, bank.kp});
    wire signed [47:0] ti = $signed({32'h0, bank.ti});
    wire signed [47:0] td = $signed({32'h0, bank.td});
    wire signed [47:0] tau = $signed({32'h0, bank.lpf});
    wire signed [47:0] dlim = $signed({32'h0, bank.dlim});
    wire signed [47:0] fbf_nxt = (bank.lpf == 16'h0000) ? fb_sum :
        fbf_r + (fb_sum - fbf_r) / tau;
    wire signed [47:0] err_raw = ref_cl - fbf_r;
    wire signed [47:0] err = inv ? -err_raw : err_raw;
    wire signed [47:0] p_term = (err * kp) >>> 8;
    wire signed [47:0] i_nxt = (bank.ti == 16'h0000) ? integ_r :
        integ_r + p_term / ti;
    wire signed [47:0] d_raw = (((err - err_prev_r) * td) * kp) >>> 8;
    wire signed [47:0] d_term = (bank.td == 16'h0000) ? 48'sh0 :
        (d_raw > dlim) ? dlim : (d_raw < -dlim) ? -dlim : d_raw;
    wire signed [47:0] out_sum = p_term + integ_r + d_term;
    wire [15:0] out_sat = (out_sum < 48'sh0) ? 16'h0000 :
        (out_sum > 48'sh00FFFF) ? 16'hFFFF : out_sum[15:0];
    wire at_limit = |pins_r.limit_hit;
    wire [15:0] start_freq = cfg_r[`DPID_IDX_START_FREQ][15:0];

    // ----------------------------------------------------------------
    // Regulation sequence
    // ----------------------------------------------------------------
    dpid_pkg::dpid_state_t state_r, state_nxt;
    logic [15:0] freq_r;
    logic active_r;

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            dpid_pkg::DPID_ST_IDLE:
                if (run)
                    state_nxt = is_prc ? dpid_pkg::DPID_ST_START :
                        dpid_pkg::DPID_ST_REG;
            dpid_pkg::DPID_ST_START:
                if (!run)
                    state_nxt = dpid_pkg::DPID_ST_IDLE;
                else if (pins_r.out_freq >= start_freq)
                    state_nxt = dpid_pkg::DPID_ST_REG;
            dpid_pkg::DPID_ST_REG:
                if (!run)
                    state_nxt = dpid_pkg::DPID_ST_IDLE;
            default:
                state_nxt = dpid_pkg::DPID_ST_IDLE;
        endcase
    end

    // Sequence register and output command
    always_ff @(posedge CLK_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r <= dpid_pkg::DPID_ST_IDLE;
            freq_r <= 16'h0000;
            active_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            active_r <= state_nxt == dpid_pkg::DPID_ST_REG;
            if (state_nxt == dpid_pkg::DPID_ST_IDLE)
                freq_r <= 16'h0000;
            else if (state_nxt == dpid_pkg::DPID_ST_START)
                freq_r <= start_freq;
            else if (tick_r)
                freq_r <= out_sat;
        end
    end

    // Term state, updated once per sample; integrator and previous error follow every cycle outside regulation
    always_ff @(posedge CLK_IN or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            fbf_r <= 48'sh0;
            integ_r <= 48'sh0;
            err_prev_r <= 48'sh0;
        end
        else
        begin
            if (tick_r)
                fbf_r <= fbf_nxt;
            if (state_r != dpid_pkg::DPID_ST_REG)
            begin
                integ_r <= {32'h0, freq_r};
                err_prev_r <= err;
            end
            else if (tick_r)
            begin
                integ_r <= (aw_en && at_limit) ?
                    {32'h0, pins_r.out_freq} : i_nxt;
                err_prev_r <= err;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status words and outputs
    // ----------------------------------------------------------------
    assign status_w = {2'b00, unit, 6'h00, state_r, freq_r};
    assign feedback_w = {fbf_r[15:0], ref_cl[15:0]};
    assign error_w = err[31:0];
    assign AVS_READDATA_OUT = rdata_r;
    assign AVS_WAITREQUEST_OUT = wait_r;
    assign FREQ_CMD_OUT = freq_r;
    assign REG_ACTIVE_OUT = active_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_req_wait;
        req && wait_r;
    endsequence
    sequence s_answer;
        !wait_r ##1 wait_r;
    endsequence

    a_bus_answer: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        s_req_wait |=> s_answer) else $error("bus answer late");
    a_idle_zero: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        state_r == dpid_pkg::DPID_ST_IDLE |-> freq_r == 16'h0000)
        else $error("idle command not zero");
    a_start_hold: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        state_r == dpid_pkg::DPID_ST_START |-> freq_r == $past(start_freq))
        else $error("start freq wrong");
    a_start_only_prc: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        $rose(state_r == dpid_pkg::DPID_ST_START) |-> $past(is_prc))
        else $error("start phase outside process");
    a_deriv_off: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        bank.td == 16'h0000 |-> d_term == 48'sh0)
        else $error("derivative active");
    a_deriv_cap: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        d_term <= dlim && d_term >= -dlim)
        else $error("derivative over limit");
    a_ref_clamp: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        fb_lo <= fb_hi |-> ref_cl <= fb_hi && ref_cl >= fb_lo)
        else $error("reference outside feedback range");
    a_aw_reload: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        tick_r && aw_en && at_limit && state_r == dpid_pkg::DPID_ST_REG
        |=> integ_r == {32'h0, $past(pins_r.out_freq)})
        else $error("anti windup reload missed");
    a_tick_space: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        tick_r |=> !tick_r) else $error("tick too frequent");
    a_inverse_sign: assert property (
        @(posedge CLK_IN) disable iff (!rst_n_r)
        inv |-> err == -(ref_cl - fbf_r))
        else $error("inverse sign wrong");
endmodule : dpid_top

// ==== tb/dpid_partner.sv ====
module dpid_partner (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [15:0] freq_cmd_in,
    input wire logic hold_in,
    output logic [15:0] out_freq_out,
    output logic [2:0] limit_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Inverter stage
    // ----------------------------------------
    // Output slews one step a cycle, so the start phase takes real time
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            out_freq_out <= 16'h0000;
        end
        else if (!hold_in && out_freq_out < freq_cmd_in)
        begin
            out_freq_out <= out_freq_out + 16'h0001;
        end
        else if (!hold_in && out_freq_out > freq_cmd_in)
        begin
            out_freq_out <= out_freq_out - 16'h0001;
        end
    end
    // Held output stands at the frequency limit
    assign limit_out = hold_in ? 3'h1 : 3'h0;
endmodule : dpid_partner

// ==== tb/dpid_top_bench.sv ====
module dpid_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 10;
    logic clk;
    logic arst_n;
    logic [6:0] addr;
    logic rd, wr, hold, reg_active;
    logic [31:0] wdata, rdata, got;
    logic waitreq;
    logic [15:0] fb_volt, fb_cur, ref_volt, ref_cur, out_freq, freq_cmd, f0;
    logic [2:0] limit;
    int num_errors, compares, n;
    logic [31:0] bank_rst [5] = '{32'h100, 32'h64, 32'h14, 32'h500, 32'h64};

    // ----------------------------------------
    // Block and far side
    // ----------------------------------------
    dpid_top #(.SAMPLE_CYC(TICK)) dut (
        .CLK_IN(clk), .ARST_N_IN(arst_n), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
        .FB_VOLT_IN(fb_volt), .FB_CUR_IN(fb_cur), .FB_PULSE_IN(16'h0000),
        .REF_VOLT_IN(ref_volt), .REF_CUR_IN(ref_cur),
        .OUT_FREQ_IN(out_freq), .LIMIT_HIT_IN(limit),
        .FREQ_CMD_OUT(freq_cmd), .REG_ACTIVE_OUT(reg_active)
    );
    dpid_partner partner (
        .clk_in(clk), .arst_n_in(arst_n), .freq_cmd_in(freq_cmd),
        .hold_in(hold), .out_freq_out(out_freq), .limit_out(limit)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_word

    // One bus transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] idx,
                       input logic [31:0] d);
        int k;
        k = 0;
        addr <= {idx, 2'b00};
        wdata <= d;
        wr <= w;
        rd <= !w;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitreq !== 1'b0 && k < 50);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
        if (k >= 50)
        begin
            check_word(32'h0, 32'h1);
        end
    endtask : bus

    task automatic rd_chk(input logic [4:0] idx, input logic [31:0] m,
                          input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        check_word(got & m, e);
    endtask : rd_chk

    task automatic print_verdict();
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        check_word(32'h0, 32'h1);
        print_verdict();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        arst_n = 1'b0;
        {addr, rd, wr, wdata, hold} = '0;
        {fb_volt, fb_cur, ref_volt, ref_cur} = '0;
        num_errors = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        check_word({15'h0, reg_active, freq_cmd}, 32'h0);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values, bus refusals, read-only fields
        rd_chk(5'h00, 32'hFFFF_FFFF, 32'h29);
        rd_chk(5'h02, 32'hFFFF_FFFF, 32'h100);
        rd_chk(5'h04, 32'hFFFF_FFFF, 32'h5DC);
        for (int k = 0; k < 10; k++)
            rd_chk(5'(8 + k), 32'hFFFF_FFFF, bank_rst[k % 5]);
        bus(1'b1, 5'h1F, 32'hFFFF_FFFF);
        rd_chk(5'h1F, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, 5'h01, 32'hFFFF_0000);
        rd_chk(5'h01, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, 5'h12, 32'hFFFF_FFFF);
        rd_chk(5'h12, 32'hFFFF_FFFF, 32'h0300_0000);
        // Summed reference clamped to feedback range
        bus(1'b1, 5'h04, 32'h64);
        bus(1'b1, 5'h05, 32'h50);
        bus(1'b1, 5'h06, 32'h3C);
        bus(1'b1, 5'h00, 32'h0C29);
        repeat (3 * TICK) @(posedge clk);
        rd_chk(5'h13, 32'hFFFF, 32'h64);
        // Max reference scales, min reference floors
        bus(1'b1, 5'h02, 32'h80);
        bus(1'b1, 5'h05, 32'h40);
        bus(1'b1, 5'h06, 32'h10);
        repeat (3 * TICK) @(posedge clk);
        rd_chk(5'h13, 32'hFFFF, 32'h28);
        bus(1'b1, 5'h01, 32'h30);
        repeat (3 * TICK) @(posedge clk);
        rd_chk(5'h13, 32'hFFFF, 32'h30);
        bus(1'b1, 5'h01, 32'h0);
        // Two feedback terminals add; current reference dropped
        ref_volt <= 16'h0010;
        ref_cur <= 16'h0010;
        fb_volt <= 16'h001E;
        fb_cur <= 16'h0014;
        bus(1'b1, 5'h0C, 32'h0);
        bus(1'b1, 5'h00, 32'h0F69);
        repeat (3 * TICK) @(posedge clk);
        rd_chk(5'h13, 32'hFFFF_FFFF, 32'h0032_0030);
        // Lowpass with two-sample constant settles a step at 31
        bus(1'b1, 5'h0C, 32'h2);
        fb_cur <= 16'h0000;
        repeat (10 * TICK) @(posedge clk);
        rd_chk(5'h13, 32'hFFFF_FFFF, 32'h001F_0030);
        // Process mode: start frequency, then regulation
        bus(1'b1, 5'h02, 32'h100);
        bus(1'b1, 5'h05, 32'h50);
        bus(1'b1, 5'h06, 32'h0);
        bus(1'b1, 5'h07, 32'h40);
        bus(1'b1, 5'h0E, 32'h1);
        bus(1'b1, 5'h0F, 32'h0);
        bus(1'b1, 5'h11, 32'h0);
        bus(1'b1, 5'h00, 32'h0005_043B);
        repeat (4) @(posedge clk);
        check_word({15'h0, reg_active, freq_cmd}, 32'h40);
        rd_chk(5'h12, 32'h3F03_0000, 32'h0501_0000);
        n = 0;
        while (reg_active !== 1'b1 && n < 500)
        begin
            @(posedge clk);
            n++;
        end
        check_word({31'h0, reg_active}, 32'h1);
        repeat (2 * TICK) @(posedge clk);
        f0 = freq_cmd;
        repeat (10 * TICK) @(posedge clk);
        check_word({31'h0, freq_cmd > f0}, 32'h1);
        f0 = freq_cmd;
        bus(1'b1, 5'h00, 32'h0005_043F);
        repeat (10 * TICK) @(posedge clk);
        check_word({31'h0, freq_cmd < f0}, 32'h1);
        // Anti-windup pins the integrator at a limit until disabled
        bus(1'b1, 5'h00, 32'h0005_043B);
        repeat (10 * TICK) @(posedge clk);
        hold <= 1'b1;
        repeat (3 * TICK) @(posedge clk);
        f0 = freq_cmd;
        repeat (10 * TICK) @(posedge clk);
        check_word({16'h0, freq_cmd}, {16'h0, f0});
        bus(1'b1, 5'h00, 32'h0005_0433);
        f0 = freq_cmd;
        repeat (10 * TICK) @(posedge clk);
        check_word({31'h0, freq_cmd > f0}, 32'h1);
        print_verdict();
    end
endmodule : dpid_top_bench
